// ### latch_off_thermal_protection.sv
// Latch-off and thermal shutdown sequencer of a flyback controller.
// Assumes digitized comparator levels synchronous to clk; rst_n is
// generated by the supply monitor.
// How it works
// - Drive only inside soft-start and run
// - Valid latch crossing enters latched-off state
// - Short crossings are blanked and ignored
// - Only brown-out, supply reset or die hot clears latch
// - Latch comparators ignored until ready to start
// - Start threshold arms high latch, then drive
// - Low latch acted on after soft-start
// - Thermistor bias doubled during soft-start
// - Die hot stops drive, startup source, state
// - Die cooled restores startup source, restarts
// - Soft-start on every start or restart
`timescale 1ns/1ps
`include "latch_params.svh"
module latch_off_thermal_protection (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Comparator levels
  input  wire latch_pkg::sense_type sense,
  // Outputs to driver, bias and startup source
  output latch_pkg::ctrl_type     ctrl,
  output logic                    gate_drive_output,
  output logic                    thermistor_bias_current,
  output logic                    high_voltage_startup_source
);
  localparam logic [`BLANK_CNT_W-1:0] HIGH_CNT =
    `BLANK_CNT_W'(`HIGH_BLANK_CYCLES);
  localparam logic [`BLANK_CNT_W-1:0] LOW_CNT =
    `BLANK_CNT_W'(`LOW_BLANK_CYCLES);
  localparam logic [`SS_CNT_W-1:0] SS_CNT =
    `SS_CNT_W'(`SOFT_START_CYCLES);

  latch_pkg::seq_state_type state_q;
  latch_pkg::seq_state_type state_d;
  logic [`SS_CNT_W-1:0]     ss_cnt_q;
  logic [`SS_CNT_W-1:0]     ss_cnt_d;
  latch_pkg::ctrl_type      ctrl_q;
  latch_pkg::ctrl_type      ctrl_d;
  logic                     high_arm;
  logic                     low_arm;
  logic                     high_valid;
  logic                     low_valid;
  logic                     clear_cond;

  // High latch armed from start threshold on; low only after soft-start
  assign high_arm = (state_q == latch_pkg::ST_SOFT_START) ||
                    (state_q == latch_pkg::ST_RUN);
  assign low_arm  = (state_q == latch_pkg::ST_RUN);

  // Per-threshold arm, crossing and qualified result
  logic [`LATCH_CH_NUM-1:0] blank_arm;
  logic [`LATCH_CH_NUM-1:0] blank_cross;
  logic [`LATCH_CH_NUM-1:0] blank_valid;

  assign blank_arm[`LATCH_CH_HIGH]   = high_arm;
  assign blank_arm[`LATCH_CH_LOW]    = low_arm;
  assign blank_cross[`LATCH_CH_HIGH] = sense.latch_high;
  assign blank_cross[`LATCH_CH_LOW]  = sense.latch_low;

  // One blanking filter per threshold, each with its own count
  for (genvar ch = 0; ch < `LATCH_CH_NUM; ch++) begin : g_blank
    crossing_blanker #(
      .COUNT ((ch == `LATCH_CH_HIGH) ? HIGH_CNT : LOW_CNT)
    ) crossing_blanker_i (
      .clk      (clk),
      .rst_n    (rst_n),
      .arm      (blank_arm[ch]),
      .crossing (blank_cross[ch]),
      .valid    (blank_valid[ch])
    );
  end

  // A crossing only counts once its filter has seen it held long enough
  assign high_valid = blank_valid[`LATCH_CH_HIGH];
  assign low_valid  = blank_valid[`LATCH_CH_LOW];

  // Any supply collapse ends soft-start, run and latched-off alike
  assign clear_cond = sense.brown_out || sense.supply_reset;

  // Soft-start progress and qualified trips, shared below
  logic ss_done;
  logic trip;

  // Last cycle of the soft-start window reached
  assign ss_done = (ss_cnt_q == SS_CNT - 1'b1);
  // Either threshold held past its blanking time
  assign trip    = high_valid || low_valid;

  // Sequencer state
  always_comb begin
    state_d = state_q;
    if (sense.die_hot) begin
      // Over-temperature wins over every other condition
      state_d = latch_pkg::ST_THERMAL;
    end else begin
      case (state_q)
        latch_pkg::ST_WAIT_START: begin
          // Latch comparators are not armed here
          if (sense.supply_start && !clear_cond) begin
            state_d = latch_pkg::ST_SOFT_START;
          end
        end
        latch_pkg::ST_SOFT_START: begin
          // Only the high threshold may trip during soft-start
          if (clear_cond) begin
            state_d = latch_pkg::ST_WAIT_START;
          end else if (high_valid) begin
            state_d = latch_pkg::ST_LATCHED;
          end else if (ss_done) begin
            state_d = latch_pkg::ST_RUN;
          end
        end
        latch_pkg::ST_RUN: begin
          // Both thresholds are live once soft-start is over
          if (clear_cond) begin
            state_d = latch_pkg::ST_WAIT_START;
          end else if (trip) begin
            state_d = latch_pkg::ST_LATCHED;
          end
        end
        latch_pkg::ST_LATCHED: begin
          // Comparator and start activity cannot release the latch
          if (clear_cond) begin
            state_d = latch_pkg::ST_WAIT_START;
          end else begin
            state_d = latch_pkg::ST_LATCHED;
          end
        end
        latch_pkg::ST_THERMAL: begin
          // Leave only once the die has cooled past recovery
          if (sense.die_cool) begin
            state_d = latch_pkg::ST_WAIT_START;
          end
        end
        default: begin
          state_d = latch_pkg::ST_WAIT_START;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= latch_pkg::ST_WAIT_START;
    end else begin
      state_q <= state_d;
    end
  end

  // Soft-start timer: runs only inside soft-start, restarts from zero
  always_comb begin
    ss_cnt_d = ss_cnt_q;
    if (sense.die_hot) begin
      ss_cnt_d = '0;
    end else if (state_q != latch_pkg::ST_SOFT_START) begin
      ss_cnt_d = '0;
    end else if (clear_cond || high_valid || ss_done) begin
      ss_cnt_d = ss_cnt_q;
    end else begin
      ss_cnt_d = ss_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ss_cnt_q <= '0;
    end else begin
      ss_cnt_q <= ss_cnt_d;
    end
  end

  // Next-state decode for the registered outputs
  logic next_soft_start;
  logic next_run;
  logic next_latched;
  logic next_thermal;

  assign next_soft_start = (state_d == latch_pkg::ST_SOFT_START);
  assign next_run        = (state_d == latch_pkg::ST_RUN);
  assign next_latched    = (state_d == latch_pkg::ST_LATCHED);
  assign next_thermal    = (state_d == latch_pkg::ST_THERMAL);

  // Output controls, registered so every pin is glitch free
  always_comb begin
    ctrl_d = '0;
    // Startup source is off in reset and in the thermal state, from die hot until the die has cooled
    ctrl_d.high_voltage_startup_source = !next_thermal;
    // Soft-start marker and doubled bias share one window
    ctrl_d.soft_start_active      = next_soft_start;
    ctrl_d.thermistor_bias_double = next_soft_start;
    ctrl_d.latched_off            = next_latched;
    // Drive only inside the window, never on a qualified crossing
    ctrl_d.gate_drive_enable = (next_soft_start || next_run) &&
                               !trip && !sense.die_hot;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl                        = ctrl_q;
  assign gate_drive_output           = ctrl_q.gate_drive_enable;
  assign thermistor_bias_current     = ctrl_q.thermistor_bias_double;
  assign high_voltage_startup_source = ctrl_q.high_voltage_startup_source;
endmodule

// ### latch_params.svh
// Named constants for the latch-off protection sequencer.
// Assumes a 20 MHz clock; times are in microseconds.
`ifndef LATCH_PARAMS_SVH
`define LATCH_PARAMS_SVH
`define CLK_MHZ            20
`define HIGH_BLANK_US      10
`define LOW_BLANK_US       10
`define HIGH_BLANK_CYCLES  (`HIGH_BLANK_US * `CLK_MHZ)
`define LOW_BLANK_CYCLES   (`LOW_BLANK_US * `CLK_MHZ)
`define SOFT_START_US      4000
`define SOFT_START_CYCLES  (`SOFT_START_US * `CLK_MHZ)
`define BLANK_CNT_W        16
`define SS_CNT_W           17
`define LATCH_CH_HIGH      0
`define LATCH_CH_LOW       1
`define LATCH_CH_NUM       2
`endif

// ### latch_pkg.sv
// Types for the latch-off protection sequencer.
// Assumes all comparator inputs are digitized and synchronous to clk.
package latch_pkg;
  typedef enum logic [2:0] {
    ST_WAIT_START,
    ST_SOFT_START,
    ST_RUN,
    ST_LATCHED,
    ST_THERMAL
  } seq_state_type;

  typedef struct packed {
    logic latch_high;
    logic latch_low;
    logic supply_start;
    logic supply_reset;
    logic brown_out;
    logic die_hot;
    logic die_cool;
  } sense_type;

  typedef struct packed {
    logic gate_drive_enable;
    logic thermistor_bias_double;
    logic high_voltage_startup_source;
    logic soft_start_active;
    logic latched_off;
  } ctrl_type;
endpackage

// ### crossing_blanker.sv
// Blanking filter: flags a crossing held for a full count of cycles.
// Assumes the input is synchronous to clk.
`timescale 1ns/1ps
`include "latch_params.svh"
module crossing_blanker #(
  parameter logic [`BLANK_CNT_W-1:0] COUNT = `BLANK_CNT_W'(1)
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic arm,
  input  wire logic crossing,
  // Result
  output logic      valid
);
  logic [`BLANK_CNT_W-1:0] cnt_q;
  logic [`BLANK_CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (!arm || !crossing) begin
      cnt_d = '0;
    end else if (cnt_q != COUNT) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign valid = arm && crossing && (cnt_q == COUNT);
endmodule

// ### prot_sva.sv
// Checker of the protection sequencer outputs against its inputs.
// Assumes it is bound to latch_off_thermal_protection.
`timescale 1ns/1ps
module prot_sva (
  // Watched ports
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire latch_pkg::sense_type sense,
  input wire latch_pkg::ctrl_type  ctrl,
  input wire logic                 gate_drive_output,
  input wire logic                 thermistor_bias_current,
  input wire logic                 high_voltage_startup_source
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_HOT: assert property (sense.die_hot |=>
    !gate_drive_output && !high_voltage_startup_source) else $error("hot");
  AST_COOL: assert property (!high_voltage_startup_source &&
    sense.die_cool && !sense.die_hot |=> high_voltage_startup_source)
    else $error("source not back");
  AST_HOLD: assert property (ctrl.latched_off && !sense.brown_out &&
    !sense.supply_reset && !sense.die_hot |=> ctrl.latched_off)
    else $error("latch lost");
  AST_CLR: assert property (sense.brown_out |=> !ctrl.latched_off)
    else $error("latch kept");
  AST_OFF: assert property (ctrl.latched_off |-> !gate_drive_output)
    else $error("drive while latched");
  AST_SRC: assert property ($rose(ctrl.latched_off) |->
    $past(sense.latch_high) || $past(sense.latch_low)) else $error("cause");
  AST_SS: assert property (ctrl.soft_start_active && !sense.latch_high
    |=> !ctrl.latched_off) else $error("low latch early");
  AST_BIAS: assert property (thermistor_bias_current ==
    ctrl.soft_start_active) else $error("bias");
endmodule
bind latch_off_thermal_protection prot_sva prot_sva_i (.clk(clk),
  .rst_n(rst_n), .sense(sense), .ctrl(ctrl),
  .gate_drive_output(gate_drive_output),
  .thermistor_bias_current(thermistor_bias_current),
  .high_voltage_startup_source(high_voltage_startup_source));

// ### sense_model.sv
// Comparators and supply monitor: levels settle one cycle after request.
// Assumes the bench sets wanted levels just after a clock edge.
`timescale 1ns/1ps
module sense_model (
  // Clock, wanted levels, comparator outputs
  input  wire logic                 clk,
  input  wire latch_pkg::sense_type level,
  output latch_pkg::sense_type      sense
);
  always @(posedge clk) sense <= level;
endmodule

// ### latch_off_thermal_protection_test.sv
// Bench: drives comparator levels and checks the protection outputs.
// Assumes the sense model, the sequencer and its bound checker.
`timescale 1ns/1ps
module latch_off_thermal_protection_test;
  logic                 clk = 1'h0;
  logic                 rst_n = 1'h0;
  latch_pkg::sense_type lv = 7'h00;
  latch_pkg::sense_type sense;
  latch_pkg::ctrl_type  ctrl;
  logic                 gate, bias, hv;
  int                   num_errors = 0;
  int                   checked = 0;
  always #25 clk = ~clk;
  sense_model sense_model_i (.clk(clk), .level(lv), .sense(sense));
  latch_off_thermal_protection latch_off_thermal_protection_i (.clk(clk),
    .rst_n(rst_n), .sense(sense), .ctrl(ctrl), .gate_drive_output(gate),
    .thermistor_bias_current(bias), .high_voltage_startup_source(hv));
  // Waits, then compares drive, bias, source and latched-off
  task automatic t(input int n, input logic [3:0] e);
    repeat (n) @(posedge clk);
    #1;
    checked++;
    if ({gate, bias, hv, ctrl.latched_off} !== e) begin
      num_errors++;
      $display("MISMATCH %0t outputs %b", $time,
        {gate, bias, hv, ctrl.latched_off});
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #4_500_000;
    num_errors++;
    conclude();
  end
  initial begin
    t(16, 4'h0);
    rst_n = 1'h1;
    t(3, 4'h2);
    lv.latch_high = 1'h1;
    t(300, 4'h2);
    lv.latch_high = 1'h0;
    lv.supply_start = 1'h1;
    t(3, 4'he);
    lv.latch_low = 1'h1;
    t(300, 4'he);
    lv.latch_low = 1'h0;
    repeat (2) begin
      lv.latch_high = 1'h1;
      t(199, 4'he);
      lv.latch_high = 1'h0;
      t(1, 4'he);
    end
    lv.latch_high = 1'h1;
    t(250, 4'h3);
    lv.latch_high = 1'h0;
    t(50, 4'h3);
    lv.brown_out = 1'h1;
    t(3, 4'h2);
    lv.brown_out = 1'h0;
    t(3, 4'he);
    t(80010, 4'ha);
    lv.latch_low = 1'h1;
    t(250, 4'h3);
    lv.latch_low = 1'h0;
    lv.supply_reset = 1'h1;
    t(3, 4'h2);
    lv.supply_reset = 1'h0;
    lv.die_hot = 1'h1;
    t(3, 4'h0);
    lv.die_hot = 1'h0;
    lv.die_cool = 1'h1;
    t(6, 4'he);
    conclude();
  end
endmodule
